//--- rtl/czc_compare.sv
// counter zone compare and table compare engine with apb register access
//
// Added by the designer: the APB interface to the registers and the register offsets.
`default_nettype none
// Behaviour
// R1 - zone result updates only on count pulses that change the counter
// R2 - after reset or start, no zone result until first count pulse
// R3 - software keeps lower value not above upper value
// R4 - each comparison value is two 16-bit words forming 32 bits
// R5 - three consecutive outputs from the base: below, inside, above
// R6 - bases 0 to 5 of an octal group refresh all three together
// R7 - table mode chosen by the table mode declare flag
// R8 - software gives line count between 1 and 128
// R9 - table line is four words: value low, value high, point, set/clear
// R10 - output point digits are held as hexadecimal digits
// R11 - set/clear 1 drives output on, 0 drives it off, immediately
// R12 - start of table mode loads first line as target
// R13 - on counter equal to target, act on output at once
// R14 - after each match, line counter plus one, next line is target
// R15 - at line count, counter to zero, reload first line, set complete
// R16 - execution condition dropped stops table and clears line counter
// R17 - outputs hold their last state until driven again
// R18 - exactly one zone output on, inclusive zone in the middle
// R19 - count update first, comparison after
// R20 - all values are signed 32-bit
// R21 - line counter readable by software
module czc_compare
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_up,
    input wire logic count_down,
    input wire logic [4:0] zone_base,
    output logic [czc_pkg::OUT_W-1:0] out_points,
    output logic table_complete_flag,
    output logic [7:0] table_line_counter
);
    import czc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } czc_state_t;

    typedef struct packed {
        czc_state_t st;
        logic [2:0] up_s;
        logic [2:0] dn_s;
        logic up_l;
        logic dn_l;
        logic enable;
        logic table_mode;
        logic [31:0] lower;
        logic [31:0] upper;
        logic [31:0] count;
        logic [31:0] lines;
        logic [7:0] tbl_base;
        logic [7:0] line;
        logic [31:0] target;
        logic [7:0] tpoint;
        logic tset;
        logic zone_armed;
        logic cmp_pend;
        logic cpl;
        logic [OUT_W-1:0] outs;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } czc_state_s_t;

    czc_state_s_t s_q, s_d;
    logic [15:0] tbl_mem [0:TBL_WORDS-1];
    logic [15:0] w0, w1, w2, w3;
    logic tbl_we;
    logic [8:0] tbl_wa;

    // point numbers are octal digits stored as hex nibbles
    function automatic logic [4:0] pt_index(input logic [7:0] hexpt);
        pt_index = {hexpt[5:4], hexpt[2:0]}; // [R10]
    endfunction

    function automatic logic [8:0] word_addr(input logic [7:0] base, input logic [7:0] ln, input logic [1:0] w);
        word_addr = 9'({base, 1'b0} + {ln, 2'b00} + 9'(w)); // [R9]
    endfunction

    // table reads combinationally so one line loads in one cycle
    assign w0 = tbl_mem[word_addr(s_q.tbl_base, s_q.line, 2'd0)];
    assign w1 = tbl_mem[word_addr(s_q.tbl_base, s_q.line, 2'd1)];
    assign w2 = tbl_mem[word_addr(s_q.tbl_base, s_q.line, 2'd2)];
    assign w3 = tbl_mem[word_addr(s_q.tbl_base, s_q.line, 2'd3)];

    logic wr_acc, rd_acc, up_ev, dn_ev, reg_hit, tbl_hit;
    assign wr_acc = psel && penable && pwrite && !s_q.rdy;
    assign rd_acc = psel && penable && !pwrite && !s_q.rdy;
    assign tbl_hit = (paddr >= 12'(ADDR_TBL)) && (paddr < 12'(ADDR_TBL) + 12'(TBL_WORDS * 4));
    // upper address bits must be zero, or table words above 0x100 would alias the registers
    assign reg_hit = (paddr[11:8] == 4'h0) && (paddr[7:0] < ADDR_TBL);
    assign tbl_we = wr_acc && tbl_hit && !(s_q.enable && s_q.table_mode);
    assign tbl_wa = 9'((paddr - 12'(ADDR_TBL)) >> 2);
    // either edge is one count, taken once second and third stages agree on a new level
    assign up_ev = (s_q.up_s[2] == s_q.up_s[1]) && (s_q.up_s[2] != s_q.up_l);
    assign dn_ev = (s_q.dn_s[2] == s_q.dn_s[1]) && (s_q.dn_s[2] != s_q.dn_l);

    always_ff @(posedge pclk) begin
        if (tbl_we) begin
            tbl_mem[tbl_wa] <= pwdata[15:0];
        end
    end

    always_comb begin
        logic [7:0] nxt;
        logic [4:0] zb;
        logic cpl_set;
        nxt = 8'h00;
        zb = zone_base;
        cpl_set = 1'b0;
        s_d = s_q;
        s_d.up_s = {s_q.up_s[1:0], count_up};
        s_d.dn_s = {s_q.dn_s[1:0], count_down};
        s_d.up_l = up_ev ? s_q.up_s[2] : s_q.up_l;
        s_d.dn_l = dn_ev ? s_q.dn_s[2] : s_q.dn_l;
        s_d.rdy = 1'b0;
        s_d.err = 1'b0;
        s_d.cmp_pend = 1'b0;
        // counting happens first; compare runs next cycle on the new value [R19]
        if (up_ev ^ dn_ev) begin
            s_d.count = up_ev ? s_q.count + 32'h0000_0001 : s_q.count - 32'h0000_0001;
            s_d.cmp_pend = 1'b1; // [R1]
        end
        if (s_q.enable && !s_q.table_mode && s_q.cmp_pend) begin
            // three points written in one cycle whatever the base [R6]
            s_d.outs[zb] = $signed(s_q.count) < $signed(s_q.lower); // [R5] [R18] [R20]
            s_d.outs[5'(zb + 5'd1)] = !($signed(s_q.count) < $signed(s_q.lower))
                && !($signed(s_q.count) > $signed(s_q.upper));
            s_d.outs[5'(zb + 5'd2)] = $signed(s_q.count) > $signed(s_q.upper);
            s_d.zone_armed = 1'b1; // [R2]
        end
        case (s_q.st)
            ST_IDLE: begin
                if (s_q.enable && s_q.table_mode) begin // [R7]
                    s_d.line = 8'h00;
                    s_d.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                s_d.target = {w1, w0}; // [R4] [R12]
                s_d.tpoint = w2[7:0];
                s_d.tset = w3[0];
                s_d.st = ST_RUN;
            end
            ST_RUN: begin
                // equality test against live count, acts the cycle after [R13]
                if (s_q.cmp_pend && s_q.count == s_q.target) begin
                    s_d.outs[pt_index(s_q.tpoint)] = s_q.tset; // [R11]
                    nxt = s_q.line + 8'h01; // [R14]
                    if (32'(nxt) >= s_q.lines) begin
                        nxt = 8'h00; // [R15]
                        s_d.cpl = 1'b1;
                        cpl_set = 1'b1;
                    end
                    s_d.line = nxt;
                    s_d.st = ST_LOAD;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        if (!s_q.enable || !s_q.table_mode) begin
            s_d.st = ST_IDLE; // [R16]
            s_d.line = 8'h00;
        end
        if (wr_acc) begin
            s_d.rdy = 1'b1;
            case (reg_hit ? paddr[7:0] : ADDR_TBL)
                ADDR_CTRL: begin
                    s_d.enable = pwdata[CTRL_EN_BIT];
                    s_d.table_mode = pwdata[CTRL_TBL_BIT];
                    if (pwdata[CTRL_EN_BIT] && !s_q.enable) begin
                        s_d.zone_armed = 1'b0; // [R2]
                    end
                end
                ADDR_LOWER: s_d.lower = pwdata; // software keeps lower <= upper [R3]
                ADDR_UPPER: s_d.upper = pwdata;
                ADDR_BASE: s_d.tbl_base = pwdata[7:0];
                ADDR_STATUS: begin
                    // hardware set wins over software clear, even with the flag already up
                    if (pwdata[STAT_CPL_BIT] && !cpl_set) begin
                        s_d.cpl = 1'b0;
                    end
                end
                ADDR_COUNT: begin
                    if (!(up_ev ^ dn_ev)) begin
                        s_d.count = pwdata;
                    end
                end
                ADDR_OUTS: s_d.outs = pwdata; // held until next drive [R17]
                ADDR_LINES: s_d.lines = pwdata; // range 1..128 is the writer's duty [R8]
                default: s_d.err = !tbl_hit;
            endcase
        end
        if (rd_acc) begin
            s_d.rdy = 1'b1;
            case (reg_hit ? paddr[7:0] : ADDR_TBL)
                ADDR_CTRL: s_d.rdata = {30'h0000_0000, s_q.table_mode, s_q.enable};
                ADDR_LOWER: s_d.rdata = s_q.lower;
                ADDR_UPPER: s_d.rdata = s_q.upper;
                ADDR_BASE: s_d.rdata = {24'h00_0000, s_q.tbl_base};
                ADDR_STATUS: s_d.rdata = {22'h00_0000, (s_q.st != ST_IDLE), s_q.cpl, s_q.line}; // [R21]
                ADDR_COUNT: s_d.rdata = s_q.count;
                ADDR_OUTS: s_d.rdata = s_q.outs;
                ADDR_LINES: s_d.rdata = s_q.lines;
                default: begin
                    s_d.rdata = ZERO32;
                    s_d.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.lines <= LINES_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.rdy;
    assign pslverr = s_q.err;
    assign out_points = s_q.outs;
    assign table_complete_flag = s_q.cpl;
    assign table_line_counter = s_q.line;

    // assertions
    sequence s_pulse;
        s_q.cmp_pend && s_q.enable && !s_q.table_mode && !wr_acc;
    endsequence

    property p_zone_only_on_pulse;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.cmp_pend && !wr_acc) |=> $stable(s_q.outs);
    endproperty
    a_zone_only_on_pulse: assert property (p_zone_only_on_pulse) else $error("outputs moved without pulse"); // [R1]

    property p_zone_onehot;
        @(posedge pclk) disable iff (!presetn)
        s_pulse |=> ($countones({s_q.outs[zone_base], s_q.outs[5'(zone_base + 5'd1)],
            s_q.outs[5'(zone_base + 5'd2)]}) == 1);
    endproperty
    a_zone_onehot: assert property (p_zone_onehot) else $error("zone result not one-hot"); // [R18]

    property p_below;
        @(posedge pclk) disable iff (!presetn)
        s_pulse ##0 ($signed(s_q.count) < $signed(s_q.lower)) |=> s_q.outs[zone_base];
    endproperty
    a_below: assert property (p_below) else $error("below point not set"); // [R5]

    property p_start_line0;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_IDLE && s_q.enable && s_q.table_mode) |=> (s_q.line == 8'h00) ##1 (s_q.st == ST_RUN);
    endproperty
    a_start_line0: assert property (p_start_line0) else $error("table start not at line 0"); // [R12]

    property p_match_act;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_RUN && s_q.cmp_pend && s_q.count == s_q.target && !wr_acc && s_q.enable && s_q.table_mode)
        |=> (s_q.outs[pt_index($past(s_q.tpoint))] == $past(s_q.tset));
    endproperty
    a_match_act: assert property (p_match_act) else $error("match did not drive point"); // [R13]

    property p_line_step;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_RUN && s_q.cmp_pend && s_q.count == s_q.target && s_q.enable && s_q.table_mode
            && 32'(s_q.line + 8'h01) < s_q.lines) |=> (s_q.line == $past(s_q.line) + 8'h01);
    endproperty
    a_line_step: assert property (p_line_step) else $error("line counter did not step"); // [R14]

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_RUN && s_q.cmp_pend && s_q.count == s_q.target && s_q.enable && s_q.table_mode
            && 32'(s_q.line + 8'h01) >= s_q.lines) |=> (s_q.line == 8'h00 && s_q.cpl);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not clear line or set flag"); // [R15]

    property p_stop_clear;
        @(posedge pclk) disable iff (!presetn)
        !s_q.enable |=> (s_q.line == 8'h00 && s_q.st == ST_IDLE);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("line counter not cleared on stop"); // [R16]

    sequence s_up_only;
        up_ev && !dn_ev;
    endsequence

    sequence s_match;
        s_q.st == ST_RUN && s_q.cmp_pend && s_q.count == s_q.target
            && s_q.enable && s_q.table_mode && !wr_acc;
    endsequence

    property p_count_first;
        @(posedge pclk) disable iff (!presetn)
        s_up_only |=> (s_q.count == $past(s_q.count) + 32'h0000_0001) && s_q.cmp_pend;
    endproperty
    a_count_first: assert property (p_count_first) else $error("count did not step before compare"); // [R19]

    property p_inside;
        @(posedge pclk) disable iff (!presetn)
        s_pulse ##0 (!($signed(s_q.count) < $signed(s_q.lower)) && !($signed(s_q.count) > $signed(s_q.upper)))
        |=> s_q.outs[5'(zone_base + 5'd1)];
    endproperty
    a_inside: assert property (p_inside) else $error("inside point not set"); // [R18]

    property p_above;
        @(posedge pclk) disable iff (!presetn)
        s_pulse ##0 ($signed(s_q.count) > $signed(s_q.upper)) |=> s_q.outs[5'(zone_base + 5'd2)];
    endproperty
    a_above: assert property (p_above) else $error("above point not set"); // [R18]

    property p_arm_on_start;
        @(posedge pclk) disable iff (!presetn)
        $rose(s_q.enable) |-> !s_q.zone_armed;
    endproperty
    a_arm_on_start: assert property (p_arm_on_start) else $error("zone armed before first pulse"); // [R2]

    property p_cpl_sticky;
        @(posedge pclk) disable iff (!presetn)
        (s_q.cpl && !wr_acc) |=> s_q.cpl;
    endproperty
    a_cpl_sticky: assert property (p_cpl_sticky) else $error("complete flag dropped without clear"); // [R15]

    property p_next_line;
        @(posedge pclk) disable iff (!presetn)
        s_match |=> (s_q.st == ST_LOAD) ##1 (s_q.st == ST_RUN);
    endproperty
    a_next_line: assert property (p_next_line) else $error("next line not loaded after match"); // [R14]

    property p_status_line;
        @(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == 12'(ADDR_STATUS)) |=> (prdata[7:0] == $past(s_q.line));
    endproperty
    a_status_line: assert property (p_status_line) else $error("status does not show line counter"); // [R21]
endmodule
`default_nettype wire

//--- rtl/czc_pkg.sv
// package: register map, field layout and sizes for the counter zone/table compare block
`default_nettype none
package czc_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOWER = 8'h04;
    localparam logic [7:0] ADDR_UPPER = 8'h08;
    localparam logic [7:0] ADDR_BASE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_OUTS = 8'h18;
    localparam logic [7:0] ADDR_LINES = 8'h1C;
    localparam logic [7:0] ADDR_TBL = 8'h80;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TBL_BIT = 1;
    localparam int STAT_LINE_LSB = 0;
    localparam int STAT_CPL_BIT = 8;
    localparam int STAT_RUN_BIT = 9;
    localparam int OUT_W = 32;
    localparam int TBL_WORDS = 512;
    localparam int MAX_LINES = 128;
    localparam logic [31:0] LINES_RST = 32'h0000_0001;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage
`default_nettype wire

//--- tb/czc_counter_model.sv
// pulse source standing in for the fast counter pins
`default_nettype none
module czc_counter_model (
    input wire logic pclk,
    output logic count_up,
    output logic count_down
);
    timeunit 1ns;
    timeprecision 1ps;
    // each toggle is one count; pins stay still between counts
    initial begin
        count_up = 1'b0;
        count_down = 1'b0;
    end
    task automatic step(input logic up);
        @(posedge pclk);
        if (up) begin
            count_up <= ~count_up;
        end else begin
            count_down <= ~count_down;
        end
    endtask
endmodule
`default_nettype wire

//--- tb/czc_compare_tb_top.sv
// self-checking testbench for the counter zone and table compare block
`default_nettype none
module czc_compare_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import czc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, count_up, count_down, table_complete_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] zone_base;
    logic [OUT_W-1:0] out_points;
    logic [7:0] table_line_counter;
    int mismatches = 0;
    int cmp_count = 0;
    czc_compare czc_compare_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_up(count_up), .count_down(count_down), .zone_base(zone_base),
        .out_points(out_points), .table_complete_flag(table_complete_flag),
        .table_line_counter(table_line_counter));
    czc_counter_model czc_counter_model_i (.pclk(pclk), .count_up(count_up), .count_down(count_down));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // master waits for pready, never for a fixed count
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {4'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        if (n >= 50) chk("pready", 32'h0, 32'h1);
        chk("pslverr", {31'h0, pslverr}, {31'h0, a == 8'h40});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // sync plus count plus compare settle well inside eight cycles
    task automatic pulse(input logic up, input int k);
        repeat (k) begin
            czc_counter_model_i.step(up);
            repeat (8) @(posedge pclk);
        end
    endtask
    task automatic test_zone();
        apb(1'b1, ADDR_LOWER, 32'h0000_03E8);
        apb(1'b1, ADDR_UPPER, 32'h0000_07D0);
        apb(1'b1, ADDR_COUNT, 32'h0000_03E7);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        repeat (8) @(posedge pclk);
        chk("zone before pulse", out_points, 32'h0000_0000);
        pulse(1'b1, 1);
        chk("zone inside", out_points, 32'h0000_0002);
        pulse(1'b0, 1);
        chk("zone below", out_points, 32'h0000_0001);
        apb(1'b1, ADDR_COUNT, 32'h0000_07D0);
        repeat (8) @(posedge pclk);
        chk("no pulse no update", out_points, 32'h0000_0001);
        pulse(1'b1, 1);
        chk("zone above", out_points, 32'h0000_0004);
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        zone_base <= 5'd5;
        apb(1'b1, ADDR_LOWER, 32'hFFFF_FFFB);
        apb(1'b1, ADDR_UPPER, 32'h0000_0005);
        apb(1'b1, ADDR_COUNT, 32'hFFFF_FFF5);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        pulse(1'b1, 1);
        chk("signed below at base 5", out_points, 32'h0000_0024);
    endtask
    task automatic test_table();
        logic [15:0] w [8];
        w = '{16'h0003, 16'h0001, 16'h0010, 16'h0001, 16'h0005, 16'h0001, 16'h0010, 16'h0000};
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, ADDR_OUTS, 32'h0000_0000);
        for (int i = 0; i < 8; i++) apb(1'b1, ADDR_TBL + 8'(4 * i), {16'h0, w[i]});
        apb(1'b1, ADDR_BASE, 32'h0000_0000);
        apb(1'b1, ADDR_LINES, 32'h0000_0002);
        apb(1'b1, ADDR_COUNT, 32'h0001_0000);
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        pulse(1'b1, 3);
        chk("first line set", out_points, 32'h0000_0100);
        chk("line step", {24'h0, table_line_counter}, 32'h1);
        pulse(1'b1, 2);
        chk("second line clear", out_points, 32'h0000_0000);
        chk("wrap", {24'h0, table_line_counter}, 32'h0);
        chk("complete", {31'h0, table_complete_flag}, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h0000_0300);
        apb(1'b1, ADDR_STATUS, 32'h0000_0100);
        chk("complete cleared", {31'h0, table_complete_flag}, 32'h0);
        apb(1'b0, ADDR_LINES, 32'h0);
        chk("line count readback", rd, 32'h0000_0002);
        pulse(1'b0, 2);
        chk("first line again", out_points, 32'h0000_0100);
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        chk("stop clears line", {24'h0, table_line_counter}, 32'h0);
        chk("outputs kept", out_points, 32'h0000_0100);
        apb(1'b0, 8'h40, 32'h0);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        zone_base = 5'd0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_zone();
        test_table();
        end_of_test();
    end
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
